// ### src/gdio_pkg.sv
// Package for the general digital I/O port: map, widths, carriers
package gdio_pkg;
  localparam int GDIO_PORT_W = 8;
  localparam int GDIO_ADDR_W = 8;
  localparam int GDIO_DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] GDIO_OFS_OUT = 8'h00;
  localparam logic [7:0] GDIO_OFS_DIR = 8'h04;
  localparam logic [7:0] GDIO_OFS_PIN = 8'h08;
  localparam logic [7:0] GDIO_OFS_CTRL = 8'h0c;
  localparam logic [7:0] GDIO_OFS_OUT_SET = 8'h10;
  localparam logic [7:0] GDIO_OFS_OUT_CLR = 8'h14;
  localparam logic [7:0] GDIO_OFS_DIR_SET = 8'h18;
  localparam logic [7:0] GDIO_OFS_DIR_CLR = 8'h1c;
  // Control register field
  localparam int GDIO_CTRL_PUD_BIT = 0;
  // Reset values
  localparam logic GDIO_RST_BIT = 1'b0;
  localparam logic GDIO_WAIT_RST = 1'b1;
  localparam logic [31:0] GDIO_RDATA_RST = 32'h0000_0000;

  // Per-pin pad drive, one bit per pin in each field
  typedef struct packed {
    logic [GDIO_PORT_W-1:0] drv_val;
    logic [GDIO_PORT_W-1:0] drv_en;
    logic [GDIO_PORT_W-1:0] pu_en;
  } gdio_pad_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [GDIO_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [GDIO_DATA_W-1:0] writedata;
  } gdio_req_t;
endpackage : gdio_pkg

// ### src/gdio_port.sv
// General digital I/O port with Avalon-MM register slave
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module gdio_port
  import gdio_pkg::*;
#(
  parameter int PORT_W = GDIO_PORT_W
) (
  input wire logic sys_clk, // 250 MHz system clock
  input wire logic rst_n, // Async reset, active low
  input wire gdio_req_t avs_req, // Avalon request group
  output logic [GDIO_DATA_W-1:0] avs_readdata, // Read data
  output logic avs_waitrequest, // High stalls the master
  input wire logic [PORT_W-1:0] pin_level_in, // Resolved pad level
  output logic [PORT_W-1:0] pin_drive_out, // Pad output value
  output logic [PORT_W-1:0] pin_drive_oe, // Pad output enable
  output logic [PORT_W-1:0] pin_pullup_en // Pad pull-up enable
);

  // three bits per pin
  // Port words: bit n of each word belongs to pin n
  logic [PORT_W-1:0] pin_direction_q;
  logic [PORT_W-1:0] pin_direction_d;
  logic [PORT_W-1:0] pin_output_value_q;
  logic [PORT_W-1:0] pin_output_value_d;
  logic [PORT_W-1:0] pin_input_q;
  // Shared by every pin of this port; each port instance has its own
  logic global_pullup_disable_q;
  logic global_pullup_disable_d;
  // Bus slave: one wait cycle, then the answer
  logic wait_q;
  logic wait_d;
  logic [GDIO_DATA_W-1:0] rdata_q;
  logic [GDIO_DATA_W-1:0] rdata_d;
  // Pad flops, gathered from the per-pin cells
  logic [PORT_W-1:0] drv_val_q;
  logic [PORT_W-1:0] drv_en_q;
  logic [PORT_W-1:0] pu_en_q;
  // Request phases
  logic req_any;
  logic req_first;
  logic access;
  logic [PORT_W-1:0] wbits;
  // Port-wide strobes, one set for all pins of the port
  logic write_output_strobe;
  logic write_direction_strobe;
  logic write_input_loc_strobe;
  logic write_ctrl_strobe;
  logic write_out_set_strobe;
  logic write_out_clr_strobe;
  logic write_dir_set_strobe;
  logic write_dir_clr_strobe;
  logic read_output_strobe;
  logic read_direction_strobe;
  logic read_pin_strobe;
  logic read_ctrl_strobe;

  // Zero-extends a port-wide value onto the data bus
  function automatic logic [GDIO_DATA_W-1:0] widen(
    input logic [PORT_W-1:0] v
  );
    logic [GDIO_DATA_W-1:0] r;
    r = '0;
    r[PORT_W-1:0] = v;
    return r;
  endfunction : widen

  // Address match, used by both the read and the write decode
  function automatic logic hit(
    input logic [GDIO_ADDR_W-1:0] a,
    input logic [7:0] ofs
  );
    return a == ofs;
  endfunction : hit

  // Access completes in the cycle that waitrequest is low
  // Limitation: a master that drops its request in the wait cycle
  // leaves the prepared read data unclaimed; nothing else is disturbed
  assign req_any = avs_req.read | avs_req.write;
  assign req_first = req_any & wait_q;
  assign access = req_any & ~wait_q;
  assign wbits = avs_req.writedata[PORT_W-1:0];

  // strobes shared per port
  // Decoded once from the address; every pin cell sees the same strobe,
  // so a wider port costs no extra decode logic
  assign write_output_strobe = access & avs_req.write &
    hit(avs_req.address, GDIO_OFS_OUT);
  assign write_direction_strobe = access & avs_req.write &
    hit(avs_req.address, GDIO_OFS_DIR);
  assign write_input_loc_strobe = access & avs_req.write &
    hit(avs_req.address, GDIO_OFS_PIN);
  assign write_ctrl_strobe = access & avs_req.write &
    hit(avs_req.address, GDIO_OFS_CTRL);
  assign write_out_set_strobe = access & avs_req.write &
    hit(avs_req.address, GDIO_OFS_OUT_SET);
  assign write_out_clr_strobe = access & avs_req.write &
    hit(avs_req.address, GDIO_OFS_OUT_CLR);
  assign write_dir_set_strobe = access & avs_req.write &
    hit(avs_req.address, GDIO_OFS_DIR_SET);
  assign write_dir_clr_strobe = access & avs_req.write &
    hit(avs_req.address, GDIO_OFS_DIR_CLR);
  assign read_output_strobe = req_first & avs_req.read &
    hit(avs_req.address, GDIO_OFS_OUT);
  assign read_direction_strobe = req_first & avs_req.read &
    hit(avs_req.address, GDIO_OFS_DIR);
  assign read_pin_strobe = req_first & avs_req.read &
    hit(avs_req.address, GDIO_OFS_PIN);
  assign read_ctrl_strobe = req_first & avs_req.read &
    hit(avs_req.address, GDIO_OFS_CTRL);

  // Bus group: waitrequest falls for exactly one cycle per access
  always_comb begin
    wait_d = GDIO_WAIT_RST;
    rdata_d = rdata_q;
    // Read data is prepared while waitrequest is high, so it is
    // registered and stands for the whole answer cycle
    if (req_first) begin
      wait_d = 1'b0;
      rdata_d = GDIO_RDATA_RST;
      if (read_output_strobe) begin
        rdata_d = widen(pin_output_value_q);
      end else if (read_direction_strobe) begin
        rdata_d = widen(pin_direction_q);
      end else if (read_pin_strobe) begin
        rdata_d = widen(pin_input_q);
      end else if (read_ctrl_strobe) begin
        rdata_d[GDIO_CTRL_PUD_BIT] = global_pullup_disable_q;
      end
    end
  end

  // Bus group flops; waitrequest rests high through reset
  // Trade-off: one wait cycle per access buys registered read data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= GDIO_WAIT_RST;
      rdata_q <= GDIO_RDATA_RST;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // Register group: at most one strobe is live in any cycle, since
  // they all come from the one address of the current access
  always_comb begin
    pin_direction_d = pin_direction_q;
    pin_output_value_d = pin_output_value_q;
    global_pullup_disable_d = global_pullup_disable_q;
    if (write_output_strobe) begin
      pin_output_value_d = wbits;
    end
    if (write_direction_strobe) begin
      pin_direction_d = wbits;
    end
    if (write_input_loc_strobe) begin
      pin_output_value_d = pin_output_value_q ^ wbits;
    end
    if (write_ctrl_strobe) begin
      global_pullup_disable_d = avs_req.writedata[GDIO_CTRL_PUD_BIT];
    end
    if (write_out_set_strobe) begin
      pin_output_value_d = pin_output_value_q | wbits;
    end
    if (write_out_clr_strobe) begin
      pin_output_value_d = pin_output_value_q & ~wbits;
    end
    if (write_dir_set_strobe) begin
      pin_direction_d = pin_direction_q | wbits;
    end
    if (write_dir_clr_strobe) begin
      pin_direction_d = pin_direction_q & ~wbits;
    end
  end

  // inputs, no pull-up
  // Register group flops; reset leaves every pin an input, pull-up off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_direction_q <= '0;
      pin_output_value_q <= '0;
      global_pullup_disable_q <= GDIO_RST_BIT;
    end else begin
      pin_direction_q <= pin_direction_d;
      pin_output_value_q <= pin_output_value_d;
      global_pullup_disable_q <= global_pullup_disable_d;
    end
  end

  // pins independent of each other
  // One cell per pin; a cell reads only its own bit of each word, so
  // an override added to one pin later touches that cell alone
  genvar g;
  generate
    for (g = 0; g < PORT_W; g = g + 1) begin : g_pin
      logic drive_en_d;
      logic drive_en_q;
      logic drive_val_d;
      logic drive_val_q;
      logic pullup_d;
      logic pullup_q;
      logic hold_d;
      logic hold_q;
      logic sample_d;
      logic sample_q;

      // Pad drive follows the next register values, so the pads
      // change at the same edge as the registers
      always_comb begin
        drive_en_d = pin_direction_d[g];
        drive_val_d = pin_output_value_d[g] & pin_direction_d[g];
        pullup_d = ~pin_direction_d[g] & pin_output_value_d[g] &
          ~global_pullup_disable_d;
      end

      // drivers off without clock
      // Async clear, so the pad floats even while the clock is stopped;
      // a synchronous clear would leave the pin driven until an edge
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          drive_en_q <= GDIO_RST_BIT;
          drive_val_q <= GDIO_RST_BIT;
          pullup_q <= GDIO_RST_BIT;
        end else begin
          drive_en_q <= drive_en_d;
          drive_val_q <= drive_val_d;
          pullup_q <= pullup_d;
        end
      end

      // Synchroniser inputs: the pad level, then the held level
      // Only the second stage reads the first; nothing else may tap
      // hold_q, since it can still be settling
      always_comb begin
        hold_d = pin_level_in[g];
        sample_d = hold_q;
      end

      // hold on falling edge
      // Stands in for the low-phase latch; one clock, opposite edge
      always_ff @(negedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          hold_q <= GDIO_RST_BIT;
        end else begin
          hold_q <= hold_d;
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          sample_q <= GDIO_RST_BIT;
        end else begin
          sample_q <= sample_d;
        end
      end

      // Gather the cell's flops into the port words
      assign drv_en_q[g] = drive_en_q;
      assign drv_val_q[g] = drive_val_q;
      assign pu_en_q[g] = pullup_q;
      assign pin_input_q[g] = sample_q;
    end
  endgenerate

  // Top outputs come straight from the flops above; no logic here,
  // so pad timing does not depend on the decode depth
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign pin_drive_out = drv_val_q;
  assign pin_drive_oe = drv_en_q;
  assign pin_pullup_en = pu_en_q;

endmodule : gdio_port
`default_nettype wire

// ### test/gdio_pads.sv
// Model of the circuitry outside the port pins
`timescale 1ns/1ps
`default_nettype none
module gdio_pads (
  input wire logic clk, // Clock
  input wire logic [7:0] drv, // Port drive value
  input wire logic [7:0] oe, // Port drive enable
  input wire logic [7:0] pu, // Pull-up enable
  input wire logic [7:0] ext, // Outside source value
  input wire logic [7:0] ext_en, // Outside source on
  output logic [7:0] level // Resolved level
);
  logic [7:0] last_q = 8'h00;
  // port driver wins, then source, pull-up; a float wanders
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level[i] = oe[i] ? drv[i] : ext_en[i] ? ext[i] : pu[i] | ~last_q[i];
    end
  end
  // Last level, so a floating line never repeats a stale value
  always_ff @(posedge clk) begin
    last_q <= level;
  end
endmodule : gdio_pads
`default_nettype wire

// ### test/gdio_port_props.sv
// Checker for the general digital I/O port
`timescale 1ns/1ps
`default_nettype none
module gdio_port_props
  import gdio_pkg::*;
#(parameter int PORT_W = GDIO_PORT_W) (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire gdio_req_t avs_req, // Request
  input wire logic [GDIO_DATA_W-1:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic [PORT_W-1:0] pin_level_in, // Pad level
  input wire logic [PORT_W-1:0] pin_drive_out, // Drive value
  input wire logic [PORT_W-1:0] pin_drive_oe, // Drive enable
  input wire logic [PORT_W-1:0] pin_pullup_en // Pull-up
);
  logic wr_ok;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // A write takes effect where waitrequest is low
  assign wr_ok = avs_req.write && !avs_waitrequest;
  a_reset_pads_idle: assert property ($rose(rst_n) |->
    pin_drive_oe == '0 && pin_pullup_en == '0) else $error("pads live");
  a_pull_input_only: assert property (
    (pin_pullup_en & pin_drive_oe) == '0) else $error("pull on output");
  a_drive_on_output: assert property (
    (pin_drive_out & ~pin_drive_oe) == '0) else $error("drive w/o oe");
  a_wait_one_cycle: assert property (avs_waitrequest &&
    (avs_req.read || avs_req.write) |=> !avs_waitrequest)
    else $error("late answer");
  a_pud_kills_pull: assert property (wr_ok &&
    avs_req.address == GDIO_OFS_CTRL && avs_req.writedata[0]
    |=> pin_pullup_en == '0) else $error("pull-up left on");
  a_unmapped_zero: assert property (avs_req.read &&
    !avs_waitrequest && avs_req.address == 8'h20 |-> avs_readdata == '0)
    else $error("unmapped data");
  a_toggle_output: assert property (wr_ok &&
    avs_req.address == GDIO_OFS_PIN |=> pin_drive_out == ($past(pin_drive_out)
    ^ ($past(avs_req.writedata[PORT_W-1:0]) & pin_drive_oe)))
    else $error("toggle wrong");
  a_hold_when_idle: assert property (avs_waitrequest |=>
    $stable(pin_drive_oe) && $stable(pin_drive_out)) else $error("drift");
endmodule : gdio_port_props
bind gdio_port gdio_port_props #(.PORT_W(PORT_W)) i_gdio_port_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_req(avs_req),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pin_level_in(pin_level_in), .pin_drive_out(pin_drive_out),
  .pin_drive_oe(pin_drive_oe), .pin_pullup_en(pin_pullup_en));
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the general digital I/O port
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gdio_pkg::*;
  logic clk, rst_n, wt;
  gdio_req_t req;
  logic [31:0] rdat;
  logic [7:0] lvl, drv, oe, pu, ext, ext_en;
  int errors, checks_done;
  gdio_port i_gdio_port (.sys_clk(clk), .rst_n(rst_n), .avs_req(req),
    .avs_readdata(rdat), .avs_waitrequest(wt), .pin_level_in(lvl),
    .pin_drive_out(drv), .pin_drive_oe(oe), .pin_pullup_en(pu));
  gdio_pads i_gdio_pads (.clk(clk), .drv(drv), .oe(oe), .pu(pu),
    .ext(ext), .ext_en(ext_en), .level(lvl));
  // 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // One access held until waitrequest is seen low; #1 lets outputs land
  // Only the watchdog ends a wait, so a hung slave cannot slip through
  task automatic bus(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    req <= '{a, !w, w, d};
    do begin
      @(posedge clk);
    end while (wt !== 1'b0);
    q = rdat;
    req.read <= 1'b0;
    req.write <= 1'b0;
    #1;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask : rd
  // Pads as {enable, value, pull-up}
  task automatic pads(input logic [23:0] e);
    chk({8'h00, oe, drv, pu}, {8'h00, e});
  endtask : pads
  task automatic t_config();
    rd(GDIO_OFS_DIR, 32'h0);
    wr(GDIO_OFS_OUT, 32'h3c);
    pads(24'h00003c);
    wr(GDIO_OFS_DIR, 32'h0f);
    pads(24'h0f0c30);
    wr(GDIO_OFS_CTRL, 32'h1);
    pads(24'h0f0c00);
    wr(GDIO_OFS_CTRL, 32'h0);
    $display("done config");
  endtask : t_config
  task automatic t_toggle();
    wr(GDIO_OFS_PIN, 32'h81);
    wr(GDIO_OFS_PIN, 32'h00);
    rd(GDIO_OFS_OUT, 32'hbd);
    pads(24'h0f0db0);
    $display("done toggle");
  endtask : t_toggle
  task automatic t_setclr();
    wr(GDIO_OFS_OUT_SET, 32'h02);
    wr(GDIO_OFS_OUT_CLR, 32'h80);
    wr(GDIO_OFS_DIR_SET, 32'h10);
    wr(GDIO_OFS_DIR_CLR, 32'h01);
    rd(GDIO_OFS_DIR, 32'h1e);
    pads(24'h1e1e21);
    $display("done setclr");
  endtask : t_setclr
  task automatic t_pins();
    ext <= 8'h41;
    ext_en <= 8'he1;
    // one access between write and pin read
    rd(GDIO_OFS_OUT, 32'h3f);
    rd(GDIO_OFS_PIN, 32'h5f);
    // New level must show within 1.5 periods, so read at once
    ext <= 8'h80;
    rd(GDIO_OFS_PIN, 32'h9e);
    wr(GDIO_OFS_OUT, 32'h3d);
    rd(GDIO_OFS_PIN, 32'h9c);
    wr(8'h20, 32'hff);
    rd(8'h20, 32'h0);
    // pull-up input to output low through tri-state
    wr(GDIO_OFS_OUT_CLR, 32'h20);
    pads(24'h1e1c01);
    wr(GDIO_OFS_DIR_SET, 32'h20);
    pads(24'h3e1c01);
    $display("done pins");
  endtask : t_pins
  task automatic t_reset_mid();
    @(posedge clk);
    rst_n <= 1'b0;
    #1 pads(24'h0);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(GDIO_OFS_OUT, 32'h0);
    $display("done reset");
  endtask : t_reset_mid
  initial begin
    rst_n = 1'b0;
    req = '0;
    ext = 8'h00;
    ext_en = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_config();
    t_toggle();
    t_setclr();
    t_pins();
    t_reset_mid();
    stop_test();
  end
  // Watchdog against a hung handshake
  initial begin
    #5000;
    errors++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
